// ### verilog/file_unary_ops.sv
// Contract
// RULE_01: Clear writes 00h to file register 0..31 and sets zero flag.
// RULE_02: Complement inverts register; dest 0 to W, 1 to file; zero flag updated.
// RULE_03: Decrement subtracts one; dest 0 to W, 1 to file; zero flag updated.
// RULE_04: Increment adds one; stored per destination select; zero flag updated.
// RULE_05: Decrement-skip stores result, flags untouched; zero result skips next, two cycles.
// RULE_06: Increment-skip stores result, flags untouched; zero result skips next, two cycles.
// RULE_07: Zero flag set when 8-bit result is zero, else cleared; wraps.
`timescale 1ns/10ps
module file_unary_ops
#(
    parameter int unsigned DATA_W = file_unary_pkg::DATA_W,
    parameter int unsigned ADDR_W = file_unary_pkg::ADDR_W
)
(
    input  wire logic                        ref_clk,
    input  wire logic                        resetn,
    input  wire logic                        op_valid,
    input  wire file_unary_pkg::unary_op_t   op_code,
    input  wire logic [ADDR_W-1:0]           op_addr,
    input  wire logic                        op_dest,
    output logic                             op_ready,
    output logic                             done_ff,
    output logic                             skip_ff,
    output logic                             zero_flag_ff,
    output logic [DATA_W-1:0]                w_reg_ff,
    output logic [DATA_W-1:0]                result_ff
);
    // Byte-wide constants and the zero test fix both sizes
    if ((DATA_W != file_unary_pkg::DATA_W) || (ADDR_W != file_unary_pkg::ADDR_W))
    begin : g_size_check
        $error("file_unary_ops serves only 8-bit data and 5-bit addresses");
    end

    // Skip variants leave status alone and may drop the next fetch
    function automatic logic op_skips
    (
        input file_unary_pkg::unary_op_t op
    );
        return (op == file_unary_pkg::minus_one_skip_zero_op)
            || (op == file_unary_pkg::plus_one_skip_zero_op);
    endfunction

    function automatic logic op_sets_zero
    (
        input file_unary_pkg::unary_op_t op
    );
        return (op == file_unary_pkg::clear_file_reg_op)
            || (op == file_unary_pkg::invert_file_reg_op)
            || (op == file_unary_pkg::minus_one_op)
            || (op == file_unary_pkg::plus_one_op);
    endfunction

    // Spare code falls out here, so it acts as a no-operation
    function automatic logic op_live
    (
        input file_unary_pkg::unary_op_t op
    );
        return op_sets_zero(op) || op_skips(op);
    endfunction

    // Clear has no destination select: it always targets the file
    function automatic logic op_has_dest
    (
        input file_unary_pkg::unary_op_t op
    );
        return op_live(op) && (op != file_unary_pkg::clear_file_reg_op);
    endfunction

    file_unary_pkg::exec_state_t state_ff;
    file_unary_pkg::exec_state_t nxt_state;
    file_unary_pkg::unary_op_t   op_ff;
    logic [ADDR_W-1:0]           addr_ff;
    logic                        dest_ff;
    logic [DATA_W-1:0]           rd_data;
    logic [DATA_W-1:0]           result;
    logic                        result_zero;
    logic                        updates_zero;
    logic                        is_skip_op;
    logic                        writes_file;
    logic                        writes_w;
    logic                        finishing;
    logic                        take_op;
    logic                        result_live;

    // Operand comes from the file, so every op spends one read cycle first
    assign take_op   = (state_ff == file_unary_pkg::st_exec) && op_ready && op_valid;
    assign finishing = (state_ff == file_unary_pkg::st_read);

    always_comb
    begin
        unique case (op_ff)
            file_unary_pkg::clear_file_reg_op:      result = file_unary_pkg::ZERO_BYTE; // RULE_01
            file_unary_pkg::invert_file_reg_op:     result = ~rd_data; // RULE_02
            file_unary_pkg::minus_one_op,
            file_unary_pkg::minus_one_skip_zero_op: result = rd_data - file_unary_pkg::ONE_BYTE; // RULE_03
            file_unary_pkg::plus_one_op,
            file_unary_pkg::plus_one_skip_zero_op:  result = rd_data + file_unary_pkg::ONE_BYTE; // RULE_04
            default:                                result = rd_data;
        endcase
    end

    assign result_zero  = (result == file_unary_pkg::ZERO_BYTE); // RULE_07
    assign is_skip_op   = op_skips(op_ff);
    assign updates_zero = op_sets_zero(op_ff); // RULE_05 RULE_06
    assign result_live  = finishing && op_live(op_ff);
    assign writes_file  = finishing
                       && ((op_ff == file_unary_pkg::clear_file_reg_op)
                           || (op_has_dest(op_ff)
                               && (dest_ff == file_unary_pkg::DEST_FILE))); // RULE_01
    assign writes_w     = finishing && op_has_dest(op_ff)
                       && (dest_ff == file_unary_pkg::DEST_W); // RULE_02 RULE_03 RULE_04

    always_comb
    begin
        unique case (state_ff)
            file_unary_pkg::st_exec: nxt_state = take_op ? file_unary_pkg::st_read
                                                         : file_unary_pkg::st_exec;
            file_unary_pkg::st_read: nxt_state = (is_skip_op && result_zero)
                                                 ? file_unary_pkg::st_skip
                                                 : file_unary_pkg::st_exec; // RULE_05 RULE_06
            file_unary_pkg::st_skip: nxt_state = file_unary_pkg::st_exec;
            default:                 nxt_state = file_unary_pkg::st_exec;
        endcase
    end

    file_ram
    #(
        .DATA_W (DATA_W),
        .ADDR_W (ADDR_W)
    )
    u_file_ram
    (
        .ref_clk (ref_clk),
        .rd_addr (op_addr),
        .rd_data (rd_data),
        .wr_en   (writes_file),
        .wr_addr (addr_ff),
        .wr_data (result)
    );

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= file_unary_pkg::st_exec;
            op_ff    <= file_unary_pkg::no_operation;
            addr_ff  <= '0;
            dest_ff  <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            if (take_op)
            begin
                op_ff   <= op_code;
                addr_ff <= op_addr;
                dest_ff <= op_dest;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            op_ready <= 1'b0;
        end
        else
        begin
            op_ready <= (nxt_state == file_unary_pkg::st_exec);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            done_ff <= 1'b0;
            skip_ff <= 1'b0;
        end
        else
        begin
            done_ff <= finishing;
            // Discarded fetch shows as a no-operation cycle
            skip_ff <= finishing && is_skip_op && result_zero; // RULE_05 RULE_06
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_ff <= file_unary_pkg::ZERO_BYTE;
        end
        else
        begin
            if (result_live)
            begin
                result_ff <= result;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            zero_flag_ff <= 1'b0;
        end
        else
        begin
            if (finishing && updates_zero)
            begin
                zero_flag_ff <= result_zero; // RULE_07
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            w_reg_ff <= file_unary_pkg::W_RESET;
        end
        else
        begin
            if (writes_w)
            begin
                w_reg_ff <= result;
            end
        end
    end
endmodule // file_unary_ops

// ### verilog/file_unary_pkg.sv
package file_unary_pkg;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned ADDR_W    = 5;
    localparam int unsigned FILE_DEPTH = 32;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;
    localparam logic [7:0]  ONE_BYTE  = 8'h01;
    localparam logic [7:0]  W_RESET   = 8'h00;
    localparam logic        DEST_W    = 1'b0;
    localparam logic        DEST_FILE = 1'b1;

    typedef enum logic [2:0]
    {
        no_operation           = 3'h0,
        clear_file_reg_op      = 3'h1,
        invert_file_reg_op     = 3'h2,
        minus_one_op           = 3'h3,
        plus_one_op            = 3'h4,
        minus_one_skip_zero_op = 3'h5,
        plus_one_skip_zero_op  = 3'h6
    } unary_op_t;

    typedef enum logic [1:0]
    {
        st_exec = 2'h0,
        st_read = 2'h1,
        st_skip = 2'h2
    } exec_state_t;
endpackage

// ### verilog/file_ram.sv
`timescale 1ns/10ps
module file_ram
#(
    parameter int unsigned DATA_W = 8,
    parameter int unsigned ADDR_W = 5
)
(
    input  wire logic              ref_clk,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [DATA_W-1:0] rd_data,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule // file_ram

// ### tb/file_unary_props.sv
`timescale 1ns/10ps
module file_unary_props
(
    input wire logic                      ref_clk,
    input wire logic                      resetn,
    input wire logic                      op_valid,
    input wire file_unary_pkg::unary_op_t op_code,
    input wire logic [4:0]                op_addr,
    input wire logic                      op_dest,
    input wire logic                      op_ready,
    input wire logic                      done_ff,
    input wire logic                      skip_ff,
    input wire logic                      zero_flag_ff,
    input wire logic [7:0]                w_reg_ff,
    input wire logic [7:0]                result_ff
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire take = op_valid && op_ready;
    wire clr  = take && op_code == file_unary_pkg::clear_file_reg_op;
    wire sk   = take && op_code > file_unary_pkg::plus_one_op;
    AST_DONE_AFTER_TAKE: assert property (take |=> !op_ready ##1 done_ff)
        else $error("done late");
    AST_CLEAR_ZERO: assert property (clr |-> ##2 result_ff == 8'h00 && zero_flag_ff)
        else $error("clear wrong");
    AST_ZERO_FOLLOWS: assert property (take && !sk && op_code != 3'h0
        |-> ##2 zero_flag_ff == (result_ff == 8'h00)) else $error("zero flag wrong");
    AST_SKIP_KEEPS_ZERO: assert property (sk |-> ##2 $stable(zero_flag_ff))
        else $error("skip changed flag");
    AST_SKIP_ON_ZERO: assert property (sk |-> ##2 skip_ff == (result_ff == 8'h00))
        else $error("skip wrong");
    AST_SKIP_STALL: assert property (skip_ff |-> done_ff && !op_ready ##1 op_ready)
        else $error("skip length wrong");
    AST_DEST_W: assert property (take && !clr && !op_dest
        && op_code != file_unary_pkg::no_operation |-> ##2 w_reg_ff == result_ff)
        else $error("w not written");
    AST_DEST_FILE: assert property (take && (clr || op_dest) |-> ##2 $stable(w_reg_ff))
        else $error("w disturbed");
    cover property (sk ##2 skip_ff);
    cover property (clr);
    cover property (take && op_dest);
endmodule // file_unary_props
bind file_unary_ops file_unary_props props (.ref_clk, .resetn, .op_valid, .op_code, .op_addr,
    .op_dest, .op_ready, .done_ff, .skip_ff, .zero_flag_ff, .w_reg_ff, .result_ff);

// ### tb/tb.sv
`timescale 1ns/10ps
module tb;
    logic                      ref_clk = 1'b0;
    logic                      resetn = 1'b0;
    logic                      op_valid = 1'b0;
    file_unary_pkg::unary_op_t op_code = file_unary_pkg::no_operation;
    logic [4:0]                op_addr = 5'h00;
    logic                      op_dest = 1'b0;
    logic                      op_ready, done_ff, skip_ff, zero_flag_ff;
    logic [7:0]                w_reg_ff, result_ff, w_exp = 8'h00;
    logic [7:0]                mem [32];
    logic                      z_exp = 1'b0;
    logic [31:0]               seed = 32'he4e420ff;
    int                        fails = 0;
    int                        tests_run = 0;
    // Code, address, dest: wrap through zero both ways, skip to W and to file, idle code
    localparam logic [8:0] corner [8] = '{9'h040, 9'h101, 9'h141, 9'h081, 9'h180, 9'h101,
        9'h0c2, 9'h000};
    always #25 ref_clk = ~ref_clk;
    file_unary_ops dut (.ref_clk, .resetn, .op_valid, .op_code, .op_addr, .op_dest, .op_ready,
        .done_ff, .skip_ff, .zero_flag_ff, .w_reg_ff, .result_ff);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [7:0] exp_value(input logic [2:0] c, input logic [7:0] v);
        return c == 3'h1 ? 8'h00 : c == 3'h2 ? ~v : c[0] ? v - 8'h01 : v + 8'h01;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic do_op(input logic [2:0] c, input logic [4:0] a, input logic d);
        logic [7:0] r;
        int n;
        for (n = 0; op_ready !== 1'b1 && n < 8; n++) @(negedge ref_clk);
        op_code = file_unary_pkg::unary_op_t'(c);
        op_addr = a;
        op_dest = d;
        op_valid = 1'b1;
        @(negedge ref_clk);
        op_valid = 1'b0;
        r = exp_value(c, mem[a]);
        if (c == 3'h1 || (c != 3'h0 && d))
            mem[a] = r;
        else if (c != 3'h0)
            w_exp = r;
        if (c != 3'h0 && c < 3'h5)
            z_exp = r == 8'h00;
        for (n = 0; done_ff !== 1'b1 && n < 4; n++) @(negedge ref_clk);
        chk("done", {7'h00, done_ff}, 8'h01);
        if (c != 3'h0)
            chk("result", result_ff, r);
        chk("w", w_reg_ff, w_exp);
        chk("zero", {7'h00, zero_flag_ff}, {7'h00, z_exp});
        chk("skip", {7'h00, skip_ff}, {7'h00, c > 3'h4 && r == 8'h00});
    endtask
    initial
    begin
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        // File has no reset, so every address is cleared first
        for (int i = 0; i < 32; i++) do_op(3'h1, i[4:0], 1'b0);
        foreach (corner[i]) do_op(corner[i][8:6], corner[i][5:1], corner[i][0]);
        for (int i = 0; i < 300; i++)
        begin
            seed = xs(seed);
            do_op(3'h1 + seed[2:0] % 3'h6, {2'h0, seed[5:3]}, seed[6]);
        end
        wrap_up();
    end
    initial
    begin
        #250000;
        fails++;
        wrap_up();
    end
endmodule // tb
